// *** src/pwm_update_defs.svh ***
// constants for the three-phase pwm update logic
// assumes inclusion by bare name from every design file that needs it
`ifndef PWM_UPDATE_DEFS_SVH
`define PWM_UPDATE_DEFS_SVH

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define CTL_CENTER_BIT 0
`define CTL_NARROW_BIT 1
`define CTL_PSC_LSB 2
`define CTL_PSC_MSB 4
`define CTL_OVF_LSB 5
`define CTL_RESET 8'h00

// -----------------------------------------------------------------
// status register, resync and reset values
// -----------------------------------------------------------------
`define STAT_UPD_BIT 7
`define RESYNC_VALUE 8'hff
`define REP_RESET 8'h00
`define CMP_RESET 16'h0000
`define CMP_ACT_MAX 13'h1fff

// -----------------------------------------------------------------
// interrupt routing
// -----------------------------------------------------------------
`define NUM_EVENTS 10
`define UPD_EVENT_IDX 8
`define NUM_VECTORS 3

`endif

// *** src/pwm_update_pkg.sv ***
// types shared by the pwm update logic and its testbench
// assumes nothing beyond a systemverilog compiler
package pwm_update_pkg;

  // software access selector, one entry per byte register
  typedef enum logic [3:0] {
    SEL_PERIOD_LO, SEL_PERIOD_HI, SEL_U_LO, SEL_U_HI,
    SEL_V_LO, SEL_V_HI, SEL_W_LO, SEL_W_HI,
    SEL_CONTROL, SEL_REPETITION, SEL_STATUS
  } reg_sel_t;

  // direction of the pwm counter
  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage

// *** src/compare_slot.sv ***
// one compare register: byte preload, write-order lock, rounded active copy
// assumes byte writes arrive as single-cycle strobes on ref_clk
`include "pwm_update_defs.svh"
module compare_slot (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // software byte writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wr_data,
  // control
  input wire logic narrow,
  input wire logic halt,
  input wire logic transfer,
  input wire logic force_xfer,
  // values
  output logic [15:0] preload,
  output logic [12:0] active
);

  logic lo_pending_r;
  logic deferred_r;
  logic half_w;
  logic [15:0] pre_nxt;

  // ---------------------------------------------------------------
  // rounding of a left-aligned 16-bit value to 13 bits
  // ---------------------------------------------------------------
  function automatic logic [12:0] round13(input logic [15:0] v);
    logic [13:0] s;
    s = {1'b0, v[15:3]} + {13'h0000, v[2]};
    round13 = s[13] ? `CMP_ACT_MAX : s[12:0];
  endfunction

  // narrow values are plain 8-bit counts in the high byte
  function automatic logic [12:0] to_active(input logic [15:0] v,
                                            input logic n);
    to_active = n ? {5'h00, v[15:8]} : round13(v);
  endfunction

  // preload after this cycle's writes
  always_comb begin
    pre_nxt = preload;
    if (wr_lo) begin
      pre_nxt[7:0] = wr_data;
    end
    if (wr_hi) begin
      pre_nxt[15:8] = wr_data;
    end
  end

  // low byte taken now or owed, high byte not written yet
  assign half_w = !narrow && !wr_hi && (lo_pending_r || wr_lo);

  // preload bytes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      preload <= `CMP_RESET;
    end else if (!halt) begin
      preload <= pre_nxt;
    end
  end

  // low byte written and high byte still owed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lo_pending_r <= 1'b0;
    end else if (!halt) begin
      if (wr_hi || narrow) begin
        lo_pending_r <= 1'b0;
      end else if (wr_lo) begin
        lo_pending_r <= 1'b1;
      end
    end
  end

  // update that hit a half-written value waits for the high byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      deferred_r <= 1'b0;
    end else if (!halt) begin
      if (transfer && !force_xfer && half_w) begin
        deferred_r <= 1'b1;
      end else if (wr_hi || force_xfer || narrow) begin
        deferred_r <= 1'b0;
      end
    end
  end

  // active copy
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active <= 13'h0000;
    end else if (!halt) begin
      if (force_xfer || (transfer && !half_w)) begin
        active <= to_active(pre_nxt, narrow);
      end else if (deferred_r && wr_hi) begin
        active <= to_active(pre_nxt, narrow);
      end
    end
  end

endmodule

// *** src/irq_route.sv ***
// gates the ten event flags by their enables and the global mask
// assumes flags are levels held until software clears them
`include "pwm_update_defs.svh"
module irq_route (
  // flags and enables
  input wire logic [`NUM_EVENTS-1:0] flags,
  input wire logic [`NUM_EVENTS-1:0] enables,
  input wire logic global_mask,
  input wire logic halt,
  // requests
  output logic [`NUM_VECTORS-1:0] irq_vec
);

  logic [`NUM_EVENTS-1:0] req;

  // per-event request, none while halted or globally masked
  assign req = flags & enables & {`NUM_EVENTS{!global_mask && !halt}};

  // ratio events, commutation group, update and sampling
  assign irq_vec[0] = |req[1:0];
  assign irq_vec[1] = |req[7:2];
  assign irq_vec[2] = |req[9:8];

endmodule

// *** src/three_phase_pwm_update_logic.sv ***
// preload, update and resync logic of a three-phase pwm generator
// assumes software byte accesses are single-cycle strobes on ref_clk
//
// How it works
// - counter-event update mid-pair waits for high byte, resync and clock start do not
// - narrow mode uses eight-bit compares plus overflow
// - overflow bit forces full duty, update clears
// - reads return preload contents
// - left-aligned compare rounded to nearest at 13 bits
// - transfer at counter event with repetition zero, or on resync or clock start
// - edge mode updates every N cycles
// - center mode counts both overflow and underflow
// - repetition counter reloads on expiry
// - update flag raised with each update
// - update pulse available on debug pin
// - all-ones status write resyncs counter
// - resync touches update flag, may interrupt
// - counter held zero while clock disabled
// - clock enable rise starts and updates all
// - halt freezes block
// - enabled unmasked flags drive three vectors
`include "pwm_update_defs.svh"
module three_phase_pwm_update_logic (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // software byte access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire pwm_update_pkg::reg_sel_t sel,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // peripheral and processor state
  input wire logic clk_enable,
  input wire logic halt_mode,
  input wire logic global_mask,
  // other interrupt sources and enables
  input wire logic [`NUM_EVENTS-1:0] other_flags,
  input wire logic [`NUM_EVENTS-1:0] int_enable,
  output logic [`NUM_VECTORS-1:0] irq_vec,
  // pwm outputs and debug
  output logic pwm_u,
  output logic pwm_v,
  output logic pwm_w,
  output logic update_debug
);
  import pwm_update_pkg::*;
  default clocking cb_chk @(posedge ref_clk); // assertion clock
  endclocking
  default disable iff (rst);

  logic [7:0] pwm_control_reg_r;
  logic [7:0] ctl_act_r;
  logic [7:0] repetition_reg_r;
  logic [7:0] rep_act_r;
  logic [7:0] rep_cnt_r;
  logic update_int_flag_r;
  logic cke_q_r;
  logic [11:0] cnt_r;
  logic [2:0] psc_cnt_r;
  count_dir_t dir_r;
  logic [3:0] slot_lo;
  logic [3:0] slot_hi;
  logic [15:0] preload [4];
  logic [12:0] active [4];
  logic [2:0] phase_pwm;
  logic [`NUM_EVENTS-1:0] all_flags;
  logic cke_rise;
  logic resync_wr;
  logic ctl_wr;
  logic stat_wr;
  logic tick;
  logic cnt_ovf;
  logic cnt_unf;
  logic cnt_evt;
  logic rep_hit;
  logic update_evt;
  logic center;
  logic narrow;
  logic [11:0] period;
  logic [7:0] rep_reload;
  logic [2:0] rd_idx;
  logic narrow_xfer;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------

  // compare slot index of a selector, 4 when none
  function automatic logic [2:0] slot_of(input reg_sel_t s);
    unique case (s)
      SEL_PERIOD_LO, SEL_PERIOD_HI: slot_of = 3'h0;
      SEL_U_LO, SEL_U_HI: slot_of = 3'h1;
      SEL_V_LO, SEL_V_HI: slot_of = 3'h2;
      SEL_W_LO, SEL_W_HI: slot_of = 3'h3;
      default: slot_of = 3'h4;
    endcase
  endfunction

  // high byte selectors
  function automatic logic is_hi(input reg_sel_t s);
    is_hi = (s == SEL_PERIOD_HI) || (s == SEL_U_HI) ||
            (s == SEL_V_HI) || (s == SEL_W_HI);
  endfunction

  assign ctl_wr = wr_en && (sel == SEL_CONTROL);
  assign stat_wr = wr_en && (sel == SEL_STATUS);
  assign resync_wr = stat_wr && (wr_data == `RESYNC_VALUE);
  assign rd_idx = slot_of(sel);

  // ---------------------------------------------------------------
  // update event
  // ---------------------------------------------------------------

  // active configuration fields
  assign center = ctl_act_r[`CTL_CENTER_BIT];
  assign narrow = ctl_act_r[`CTL_NARROW_BIT];
  assign period = narrow ? {4'h0, active[0][7:0]} : active[0][11:0];
  assign narrow_xfer = update_evt ?
                       pwm_control_reg_r[`CTL_NARROW_BIT] : narrow;

  assign cke_rise = clk_enable && !cke_q_r;
  assign tick = clk_enable &&
                (psc_cnt_r == ctl_act_r[`CTL_PSC_MSB:`CTL_PSC_LSB]);
  assign cnt_ovf = tick && (dir_r == DIR_UP) && (cnt_r >= period);
  assign cnt_unf = tick && center && (dir_r == DIR_DOWN) &&
                   (cnt_r <= 12'h001);
  // edge mode paces on overflow only, center on both ends
  assign cnt_evt = cnt_ovf || cnt_unf;
  assign rep_hit = cnt_evt && (rep_cnt_r == 8'h00);
  // one event, three causes
  assign update_evt = rep_hit || resync_wr || cke_rise;
  assign rep_reload = (rep_act_r == 8'h00) ? 8'h00 : rep_act_r - 8'h01;

  // clock enable edge detector
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cke_q_r <= 1'b0;
    end else if (!halt_mode) begin
      cke_q_r <= clk_enable;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------

  // control preload; overflow bits cleared on update, writes win
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwm_control_reg_r <= `CTL_RESET;
    end else if (!halt_mode) begin
      if (ctl_wr) begin
        pwm_control_reg_r <= wr_data;
      end else if (update_evt) begin
        pwm_control_reg_r[`CTL_OVF_LSB+:3] <= 3'h0;
      end
    end
  end

  // repetition preload
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      repetition_reg_r <= `REP_RESET;
    end else if (!halt_mode && wr_en && sel == SEL_REPETITION) begin
      repetition_reg_r <= wr_data;
    end
  end

  // active control and repetition, moved only on update
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_act_r <= `CTL_RESET;
      rep_act_r <= `REP_RESET;
    end else if (!halt_mode && update_evt) begin
      ctl_act_r <= pwm_control_reg_r;
      rep_act_r <= repetition_reg_r;
    end
  end

  // update flag: any update sets it, a write with bit 7 low clears it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      update_int_flag_r <= 1'b0;
    end else if (!halt_mode) begin
      if (update_evt) begin
        update_int_flag_r <= 1'b1;
      end else if (stat_wr && !wr_data[`STAT_UPD_BIT]) begin
        update_int_flag_r <= 1'b0;
      end
    end
  end

  // read port returns preloads, never active copies
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (!halt_mode && rd_en) begin
      if (rd_idx != 3'h4) begin
        rd_data <= is_hi(sel) ? preload[rd_idx[1:0]][15:8] :
                                preload[rd_idx[1:0]][7:0];
      end else if (sel == SEL_CONTROL) begin
        rd_data <= pwm_control_reg_r;
      end else if (sel == SEL_REPETITION) begin
        rd_data <= repetition_reg_r;
      end else begin
        rd_data <= {update_int_flag_r, 7'h00};
      end
    end
  end

  // ---------------------------------------------------------------
  // compare registers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_slot
    assign slot_lo[i] = wr_en && (slot_of(sel) == 3'(i)) && !is_hi(sel);
    assign slot_hi[i] = wr_en && (slot_of(sel) == 3'(i)) && is_hi(sel);
    compare_slot u_slot (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_lo(slot_lo[i]),
      .wr_hi(slot_hi[i]),
      .wr_data(wr_data),
      .narrow(narrow_xfer),
      .halt(halt_mode),
      .transfer(rep_hit),
      .force_xfer(resync_wr || cke_rise),
      .preload(preload[i]),
      .active(active[i])
    );
  end

  // ---------------------------------------------------------------
  // counter, prescaler and repetition
  // ---------------------------------------------------------------

  // prescaler divides by field value plus one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      psc_cnt_r <= 3'h0;
    end else if (!halt_mode) begin
      if (!clk_enable || resync_wr || tick) begin
        psc_cnt_r <= 3'h0;
      end else begin
        psc_cnt_r <= psc_cnt_r + 3'h1;
      end
    end
  end

  // pwm counter, held at zero while the clock is off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= 12'h000;
      dir_r <= DIR_UP;
    end else if (!halt_mode) begin
      if (!clk_enable || resync_wr) begin
        cnt_r <= 12'h000;
        dir_r <= DIR_UP;
      end else if (tick) begin
        if (cnt_ovf && center) begin
          cnt_r <= cnt_r - 12'h001;
          dir_r <= DIR_DOWN;
        end else if (cnt_ovf) begin
          cnt_r <= 12'h000;
        end else if (cnt_unf) begin
          cnt_r <= 12'h000;
          dir_r <= DIR_UP;
        end else if (dir_r == DIR_UP) begin
          cnt_r <= cnt_r + 12'h001;
        end else begin
          cnt_r <= cnt_r - 12'h001;
        end
      end
    end
  end

  // repetition down-counter, reloads whenever it expires
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rep_cnt_r <= 8'h00;
    end else if (!halt_mode) begin
      if (cke_rise || resync_wr) begin
        rep_cnt_r <= (repetition_reg_r == 8'h00) ? 8'h00 :
                     repetition_reg_r - 8'h01;
      end else if (rep_hit) begin
        rep_cnt_r <= rep_reload;
      end else if (cnt_evt) begin
        rep_cnt_r <= rep_cnt_r - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // compare against the counter extended to 13 bits
  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign phase_pwm[p] = pwm_control_reg_r[`CTL_OVF_LSB+p] ||
                          ({1'b0, cnt_r} < active[p+1]);
  end

  // registered pwm and debug pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwm_u <= 1'b0;
      pwm_v <= 1'b0;
      pwm_w <= 1'b0;
      update_debug <= 1'b0;
    end else if (!halt_mode) begin
      pwm_u <= clk_enable && phase_pwm[0];
      pwm_v <= clk_enable && phase_pwm[1];
      pwm_w <= clk_enable && phase_pwm[2];
      update_debug <= update_evt;
    end
  end

  // flag vector with the update flag in its slot
  always_comb begin
    all_flags = other_flags;
    all_flags[`UPD_EVENT_IDX] = update_int_flag_r;
  end

  irq_route u_irq (
    .flags(all_flags),
    .enables(int_enable),
    .global_mask(global_mask),
    .halt(halt_mode),
    .irq_vec(irq_vec)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_stop_holds_zero: assert property (!clk_enable && !halt_mode |=>
    cnt_r == 12'h000) else $error("counter not held at zero");
  a_start_updates: assert property (cke_rise && !halt_mode |=>
    update_int_flag_r && update_debug &&
    ctl_act_r == $past(pwm_control_reg_r)) else $error("no start update");
  a_resync_effect: assert property (resync_wr && !halt_mode |=>
    cnt_r == 12'h000 && update_int_flag_r) else $error("resync missed");
  a_update_cause: assert property (update_debug |->
    $past(cnt_evt && rep_cnt_r == 8'h00) || $past(resync_wr) ||
    $past(cke_rise)) else $error("update without a legal cause");
  a_ovf_cleared: assert property (update_evt && !ctl_wr &&
    !halt_mode |=> pwm_control_reg_r[`CTL_OVF_LSB+:3] == 3'h0)
    else $error("overflow bits survived update");
  a_ovf_full_duty: assert property (pwm_control_reg_r[`CTL_OVF_LSB] &&
    clk_enable && !halt_mode |=> pwm_u) else $error("no full duty");
  a_rep_reload: assert property (rep_hit && !resync_wr && !cke_rise &&
    !halt_mode |=> rep_cnt_r == $past(rep_reload))
    else $error("repetition counter did not reload");
  a_rep_decrement: assert property (cnt_evt && rep_cnt_r != 8'h00 &&
    !update_evt && !halt_mode |=> rep_cnt_r == $past(rep_cnt_r) - 8'h01)
    else $error("repetition counter missed a count");
  a_update_irq: assert property (update_int_flag_r && !halt_mode &&
    int_enable[`UPD_EVENT_IDX] && !global_mask |-> irq_vec[2])
    else $error("enabled update flag raised no request");
  a_read_preload: assert property (rd_en && sel == SEL_REPETITION &&
    !halt_mode |=> rd_data == $past(repetition_reg_r))
    else $error("read did not return preload");

endmodule

// *** testbench/pwm_sink.sv ***
// channel manager stand-in: counts pwm high cycles and update pulses
// assumes the bench pulses clr for one cycle to open a window
module pwm_sink (
  // clock and window control
  input wire logic ref_clk,
  input wire logic clr,
  // observed block outputs
  input wire logic pwm_u,
  input wire logic pwm_v,
  input wire logic pwm_w,
  input wire logic update_debug,
  // counts since the last clear
  output logic [15:0] cnt_u,
  output logic [15:0] cnt_v,
  output logic [15:0] cnt_w,
  output logic [15:0] cnt_upd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  // high cycles per phase and debug pulses per window
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      cnt_u <= 16'h0000;
      cnt_v <= 16'h0000;
      cnt_w <= 16'h0000;
      cnt_upd <= 16'h0000;
    end else begin
      cnt_u <= cnt_u + {15'h0000, pwm_u};
      cnt_v <= cnt_v + {15'h0000, pwm_v};
      cnt_w <= cnt_w + {15'h0000, pwm_w};
      cnt_upd <= cnt_upd + {15'h0000, update_debug};
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the three-phase pwm update logic
// assumes design files and pwm_sink are compiled before it
`include "pwm_update_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_update_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk, rst, wr_en, rd_en, clk_enable, halt_mode, global_mask;
  reg_sel_t sel;
  logic [7:0] wr_data, rd_data;
  logic [`NUM_EVENTS-1:0] other_flags, int_enable;
  logic [`NUM_VECTORS-1:0] irq_vec;
  logic pwm_u, pwm_v, pwm_w, update_debug, clr;
  logic [15:0] cnt_u, cnt_v, cnt_w, cnt_upd;
  int err_count;
  int checks;
  // start-up compare bytes: period 8, u 4, v 0, w 9 left-aligned
  logic [7:0] prog [8] = '{8'h40, 8'h00, 8'h20, 8'h00,
                           8'h00, 8'h00, 8'h48, 8'h00};
  logic [9:0] fl [4] = '{10'h001, 10'h004, 10'h200, 10'h100};
  logic [2:0] vx [4] = '{3'b001, 3'b010, 3'b100, 3'b000};
  // ---------------------------------------------------------------
  // instances and clock
  // ---------------------------------------------------------------
  three_phase_pwm_update_logic uut (.ref_clk(ref_clk), .rst(rst),
    .wr_en(wr_en), .rd_en(rd_en), .sel(sel), .wr_data(wr_data),
    .rd_data(rd_data), .clk_enable(clk_enable), .halt_mode(halt_mode),
    .global_mask(global_mask), .other_flags(other_flags),
    .int_enable(int_enable), .irq_vec(irq_vec), .pwm_u(pwm_u),
    .pwm_v(pwm_v), .pwm_w(pwm_w), .update_debug(update_debug));
  pwm_sink sink (.ref_clk(ref_clk), .clr(clr), .pwm_u(pwm_u),
    .pwm_v(pwm_v), .pwm_w(pwm_w), .update_debug(update_debug),
    .cnt_u(cnt_u), .cnt_v(cnt_v), .cnt_w(cnt_w), .cnt_upd(cnt_upd));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  // compare, count and report
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one byte write, strobe for one edge
  task automatic wr(input reg_sel_t s, input logic [7:0] d);
    @(negedge ref_clk);
    sel = s;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge ref_clk);
    wr_en = 1'b0;
  endtask
  // one byte read, data judged the cycle after the strobe
  task automatic rd(input string n, input reg_sel_t s, input logic [7:0] e);
    @(negedge ref_clk);
    sel = s;
    rd_en = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    chk(n, {8'h00, e}, {8'h00, rd_data});
  endtask
  // debug pulse must show within a few cycles
  task automatic see_upd(input string n);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      if (update_debug === 1'b1) seen = 1'b1;
      @(negedge ref_clk);
    end
    chk(n, 16'h0001, {15'h0000, seen});
  endtask
  // settle, then count outputs over n cycles
  task automatic win(input int n, input logic [15:0] eu, ev, ew, ed);
    repeat (30) @(negedge ref_clk);
    clr = 1'b1;
    @(negedge ref_clk);
    clr = 1'b0;
    repeat (n) @(negedge ref_clk);
    chk("duty_u", eu, cnt_u);
    chk("duty_v", ev, cnt_v);
    chk("duty_w", ew, cnt_w);
    chk("updates", ed, cnt_upd);
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // resync while stopped, interrupt routing, halt freeze
  task automatic t_irq();
    int_enable = 10'h100;
    wr(SEL_STATUS, 8'hff);
    see_upd("resync_dbg");
    rd("flag_set", SEL_STATUS, 8'h80);
    chk("irq_upd", 16'h0004, {13'h0000, irq_vec});
    global_mask = 1'b1;
    @(negedge ref_clk);
    chk("irq_mask", 16'h0000, {13'h0000, irq_vec});
    global_mask = 1'b0;
    halt_mode = 1'b1;
    @(negedge ref_clk);
    chk("irq_halt", 16'h0000, {13'h0000, irq_vec});
    wr(SEL_STATUS, 8'h7f);
    halt_mode = 1'b0;
    rd("halt_frozen", SEL_STATUS, 8'h80);
    wr(SEL_STATUS, 8'h7f);
    rd("flag_clr", SEL_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      other_flags = fl[i];
      int_enable = 10'h000;
      @(negedge ref_clk);
      chk("irq_off", 16'h0000, {13'h0000, irq_vec});
      int_enable = 10'h3ff;
      @(negedge ref_clk);
      chk("irq_on", {13'h0000, vx[i]}, {13'h0000, irq_vec});
    end
    other_flags = 10'h000;
    int_enable = 10'h000;
  endtask
  // load compares in byte pairs, then start the counter
  task automatic t_start();
    for (int i = 0; i < 8; i++) begin
      wr(reg_sel_t'(i[3:0]), prog[i]);
    end
    rd("u_pre", SEL_U_LO, 8'h20);
    chk("pwm_stop", 16'h0000, {13'h0000, pwm_u, pwm_v, pwm_w});
    clk_enable = 1'b1;
    see_upd("cke_dbg");
    rd("cke_flag", SEL_STATUS, 8'h80);
    wr(SEL_STATUS, 8'h7f);
    win(90, 16'd40, 16'd0, 16'd90, 16'd10);
  endtask
  // low byte alone is held back, rounding on transfer
  task automatic t_defer();
    wr(SEL_U_LO, 8'h30);
    win(90, 16'd40, 16'd0, 16'd90, 16'd10);
    wr(SEL_U_HI, 8'h00);
    win(90, 16'd60, 16'd0, 16'd90, 16'd10);
    wr(SEL_U_LO, 8'h24);
    wr(SEL_U_HI, 8'h00);
    rd("u_unround", SEL_U_LO, 8'h24);
    win(90, 16'd50, 16'd0, 16'd90, 16'd10);
  endtask
  // repetition in edge then center mode
  task automatic t_rep();
    wr(SEL_REPETITION, 8'h03);
    wr(SEL_STATUS, 8'hff);
    wr(SEL_STATUS, 8'h7f);
    win(270, 16'd150, 16'd0, 16'd270, 16'd10);
    wr(SEL_CONTROL, 8'h01);
    wr(SEL_REPETITION, 8'h02);
    wr(SEL_STATUS, 8'hff);
    wr(SEL_STATUS, 8'h7f);
    win(160, 16'd90, 16'd0, 16'd160, 16'd10);
  endtask
  // narrow compares and overflow bit cleared by update
  task automatic t_narrow();
    wr(SEL_REPETITION, 8'hff);
    wr(SEL_CONTROL, 8'h02);
    wr(SEL_PERIOD_HI, 8'h08);
    wr(SEL_U_HI, 8'h02);
    wr(SEL_STATUS, 8'hff);
    wr(SEL_STATUS, 8'h7f);
    wr(SEL_CONTROL, 8'h22);
    win(90, 16'd90, 16'd0, 16'd0, 16'd0);
    repeat (2400) @(negedge ref_clk);
    rd("ovf_clr", SEL_CONTROL, 8'h02);
    win(90, 16'd20, 16'd0, 16'd0, 16'd0);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  // reset, then every scenario in turn
  initial begin
    err_count = 0;
    checks = 0;
    rst = 1'b1;
    {wr_en, rd_en, clk_enable, halt_mode, global_mask, clr} = 6'h00;
    sel = SEL_STATUS;
    wr_data = 8'h00;
    other_flags = 10'h000;
    int_enable = 10'h000;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    rd("status_rst", SEL_STATUS, 8'h00);
    rd("u_rst", SEL_U_LO, 8'h00);
    t_irq();
    t_start();
    t_defer();
    t_rep();
    t_narrow();
    summarize();
  end
  // cut a hang short
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
endmodule
